// File: rtl/pmx_pkg.sv
// pmx_pkg: constants, types and carriers for the pad reset-state and function mux
package pmx_pkg;
   localparam int NUM_PADS  = 16;
   localparam int NUM_SLOTS = 4;
   localparam int NUM_SEL   = 4;
   localparam int IDX_W     = 4;
   typedef logic [NUM_PADS-1:0] pmx_vec_t;
   // ------------------------------------------------------------
   // fixed pad roles
   // ------------------------------------------------------------
   localparam int PAD_BOOT = 0;
   localparam int PAD_ABS  = 1;
   localparam int PAD_RST  = 2;
   localparam int PAD_TDO  = 6;
   localparam int PAD_GPIO = 13;
   localparam int PAD_SRC  = 5;
   localparam pmx_vec_t JTAG_PU_MASK = 16'h0038;
   localparam pmx_vec_t CRYSTAL_OUT_MASK    = 16'h0180;
   localparam pmx_vec_t TRACE_MASK   = 16'h1E00;
   localparam pmx_vec_t ANALOG_MASK  = 16'hC000;
   localparam pmx_vec_t WAKEUP_MASK  = 16'h2003;
   localparam pmx_vec_t NO_DRV_MASK  = ANALOG_MASK | CRYSTAL_OUT_MASK;
   // slots holding an output function, slot 3 first
   localparam logic [NUM_SLOTS-1:0][NUM_PADS-1:0] SLOT_PRESENT =
      {16'h2040, 16'h2038, 16'h3E3B, 16'h3E7F};
   // ------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------
   localparam logic [7:0] REG_PCR_LAST = 8'h3C;
   localparam logic [7:0] REG_NMI      = 8'h40;
   localparam logic [7:0] REG_SRC      = 8'h44;
   localparam logic [7:0] REG_STAT     = 8'h48;
   localparam logic [7:0] REG_LEVEL    = 8'h4C;
   localparam int PCR_W       = 3;
   localparam int ALT_FUNC_FIELD_LSB  = 0;
   localparam int INPUT_BUFFER_ENABLE_BIT = 2;
   localparam int NMI_EN_BIT  = 0;
   localparam int NMI_IDX_LSB = 4;
   localparam int SRC_W       = 4;
   localparam logic [PCR_W-1:0]         PCR_RST     = 3'h0;
   localparam logic [IDX_W-1:0]         NMI_IDX_RST = 4'h0;
   localparam logic [NUM_SEL*SRC_W-1:0] SRC_RST     = 16'h0000;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {PH_PWR, PH_RST, PH_RUN} pmx_phase_e;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } pmx_bus_s;
   typedef struct packed {
      pmx_vec_t out;
      pmx_vec_t oe;
      pmx_vec_t pu;
      pmx_vec_t pd;
      pmx_vec_t ibe;
   } pmx_pad_s;
   typedef struct packed {
      pmx_vec_t out;
      pmx_vec_t oe;
   } pmx_func_s;
endpackage

// File: rtl/pmx_sync.sv
// pmx_sync: two-flop synchroniser for pad input levels
`timescale 1ns/1ps
module pmx_sync #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // levels
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] s1_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_q <= '0;
         q    <= '0;
      end else begin
         s1_q <= d;
         q    <= s1_q;
      end
   end
endmodule // pmx_sync

// File: rtl/pmx_in_sel.sv
// pmx_in_sel: picks one pad level for a module input
`timescale 1ns/1ps
module pmx_in_sel (
   // candidates
   input  wire pmx_pkg::pmx_vec_t          pads,
   // choice
   input  wire logic [pmx_pkg::IDX_W-1:0] sel,
   output logic                          y
);
   assign y = pads[sel];
endmodule // pmx_in_sel

// File: rtl/pmx_top.sv
// pmx_top: pad reset-state sequencing, function mux and input routing
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - during power-up every pad is tristate with no pull.
// - after power-up the boot-source pad has a pull-down and a low level selects flash boot.
// - after power-up the first alternate-boot-select pad has a pull-up, others stay tristate.
// - the reset pad is driven low after power-up and becomes a pull-up after the second phase.
// - after power-up the jtag clock, mode and data-in pads pull up while data-out floats.
// - precise analog pads are never driven.
// - the crystal pads stay high impedance.
// - after power-up the trace output pads are forced to output.
// - the two-bit function field picks function zero to three for the pad output.
// - pad inputs reach modules only when the input-buffer enable is set, whatever the field; the nmi source pad level bypasses it.
// - every pad input is routed, and a per-input source field picks among candidate pads.
// - a pad chosen as nmi source loses its function output enable unless it is a trace pad; its out level still follows the field.
// - every wakeup-capable pad also raises an external interrupt request.
module pmx_top (
   // clock and reset
   input  wire logic                                      clk,
   input  wire logic                                      rst_b,
   // reset phase progress
   input  wire logic                                      power_up_done,
   input  wire logic                                      second_reset_phase_done,
   // register port
   input  wire pmx_pkg::pmx_bus_s                         bus_i,
   output logic [31:0]                                    rdata_q,
   // pads
   input  wire pmx_pkg::pmx_vec_t                         pad_in,
   output pmx_pkg::pmx_pad_s                              pad_q,
   // peripheral functions
   input  wire pmx_pkg::pmx_func_s [pmx_pkg::NUM_SLOTS-1:0] func_i,
   output pmx_pkg::pmx_vec_t                              periph_in_q,
   output logic [pmx_pkg::NUM_SEL-1:0]                    sel_in_q,
   output logic                                           nmi_q,
   output pmx_pkg::pmx_vec_t                              wakeup_q,
   output pmx_pkg::pmx_vec_t                              ext_irq_q,
   // boot straps
   output logic                                           boot_from_flash_q,
   output logic                                           alt_boot_select_bit0_q
);
   localparam int IW = pmx_pkg::IDX_W;

   pmx_pkg::pmx_phase_e                            phase_q, phase_d;
   logic                                           boot_from_flash_d;
   logic                                           alt_boot_select_bit0_d;
   logic [pmx_pkg::NUM_PADS-1:0][pmx_pkg::PCR_W-1:0] pcr_q, pcr_d;
   logic                                           nmi_en_q, nmi_en_d;
   logic [IW-1:0]                                  nmi_idx_q, nmi_idx_d;
   logic [pmx_pkg::NUM_SEL*pmx_pkg::SRC_W-1:0]      src_q, src_d;
   logic [31:0]                                    rdata_d;
   logic                                           pcr_hit;
   pmx_pkg::pmx_vec_t                              pad_sync;
   pmx_pkg::pmx_vec_t                              mux_out, mux_oe, nmi_hit, ibe_vec, live;
   pmx_pkg::pmx_pad_s                              pad_d;
   pmx_pkg::pmx_vec_t                              periph_in_d, wakeup_d, ext_irq_d;
   logic [pmx_pkg::NUM_SEL-1:0]                    sel_raw, sel_in_d;
   logic                                           nmi_d;

   // ------------------------------------------------------------
   // pad input synchroniser
   // ------------------------------------------------------------
   pmx_sync #(.W(pmx_pkg::NUM_PADS)) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (pad_in),
      .q     (pad_sync)
   );

   // ------------------------------------------------------------
   // reset phase sequencer
   // ------------------------------------------------------------
   always_comb begin
      phase_d                = phase_q;
      boot_from_flash_d      = boot_from_flash_q;
      alt_boot_select_bit0_d = alt_boot_select_bit0_q;
      unique case (phase_q)
         pmx_pkg::PH_PWR: begin
            if (power_up_done) begin
               phase_d = pmx_pkg::PH_RST;
            end
         end
         pmx_pkg::PH_RST: begin
            if (second_reset_phase_done) begin
               phase_d                = pmx_pkg::PH_RUN;
               boot_from_flash_d      = !pad_sync[pmx_pkg::PAD_BOOT];
               alt_boot_select_bit0_d = pad_sync[pmx_pkg::PAD_ABS];
            end
         end
         pmx_pkg::PH_RUN: begin
            phase_d = pmx_pkg::PH_RUN;
         end
         default: begin
            phase_d = pmx_pkg::PH_PWR;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         phase_q                <= pmx_pkg::PH_PWR;
         boot_from_flash_q      <= 1'b0;
         alt_boot_select_bit0_q <= 1'b0;
      end else begin
         phase_q                <= phase_d;
         boot_from_flash_q      <= boot_from_flash_d;
         alt_boot_select_bit0_q <= alt_boot_select_bit0_d;
      end
   end

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   assign pcr_hit = (bus_i.addr <= pmx_pkg::REG_PCR_LAST) && (bus_i.addr[1:0] == 2'h0);

   always_comb begin
      pcr_d     = pcr_q;
      nmi_en_d  = nmi_en_q;
      nmi_idx_d = nmi_idx_q;
      src_d     = src_q;
      rdata_d   = 32'h0000_0000;
      if (bus_i.we) begin
         if (pcr_hit) begin
            pcr_d[bus_i.addr[5:2]] = bus_i.wdata[pmx_pkg::PCR_W-1:0];
         end else if (bus_i.addr == pmx_pkg::REG_NMI) begin
            nmi_en_d  = bus_i.wdata[pmx_pkg::NMI_EN_BIT];
            nmi_idx_d = bus_i.wdata[pmx_pkg::NMI_IDX_LSB +: IW];
         end else if (bus_i.addr == pmx_pkg::REG_SRC) begin
            src_d = bus_i.wdata[pmx_pkg::NUM_SEL*pmx_pkg::SRC_W-1:0];
         end
      end
      if (bus_i.re) begin
         if (pcr_hit) begin
            rdata_d = 32'(pcr_q[bus_i.addr[5:2]]);
         end else if (bus_i.addr == pmx_pkg::REG_NMI) begin
            rdata_d = {24'h000000, nmi_idx_q, 3'h0, nmi_en_q};
         end else if (bus_i.addr == pmx_pkg::REG_SRC) begin
            rdata_d = 32'(src_q);
         end else if (bus_i.addr == pmx_pkg::REG_STAT) begin
            rdata_d = {28'h0000000, alt_boot_select_bit0_q, boot_from_flash_q, phase_q};
         end else if (bus_i.addr == pmx_pkg::REG_LEVEL) begin
            rdata_d = 32'(pad_sync);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pcr_q     <= {pmx_pkg::NUM_PADS{pmx_pkg::PCR_RST}};
         nmi_en_q  <= 1'b0;
         nmi_idx_q <= pmx_pkg::NMI_IDX_RST;
         src_q     <= pmx_pkg::SRC_RST;
         rdata_q   <= 32'h0000_0000;
      end else begin
         pcr_q     <= pcr_d;
         nmi_en_q  <= nmi_en_d;
         nmi_idx_q <= nmi_idx_d;
         src_q     <= src_d;
         rdata_q   <= rdata_d;
      end
   end

   // ------------------------------------------------------------
   // per-pad function mux
   // ------------------------------------------------------------
   for (genvar i = 0; i < pmx_pkg::NUM_PADS; i++) begin : g_pad
      logic [1:0] af;
      assign af         = pcr_q[i][pmx_pkg::ALT_FUNC_FIELD_LSB +: 2];
      assign nmi_hit[i] = nmi_en_q && (nmi_idx_q == IW'(i));
      assign ibe_vec[i] = pcr_q[i][pmx_pkg::INPUT_BUFFER_ENABLE_BIT];
      assign mux_out[i] = func_i[af].out[i];
      assign mux_oe[i]  = func_i[af].oe[i] && pmx_pkg::SLOT_PRESENT[af][i]
                          && !nmi_hit[i] && !pmx_pkg::NO_DRV_MASK[i];
   end

   // ------------------------------------------------------------
   // pad state per phase
   // ------------------------------------------------------------
   always_comb begin
      pad_d = '0;
      unique case (phase_q)
         pmx_pkg::PH_PWR: begin
            pad_d = '0;
         end
         pmx_pkg::PH_RST: begin
            pad_d.pd[pmx_pkg::PAD_BOOT] = 1'b1;
            pad_d.pu[pmx_pkg::PAD_ABS]  = 1'b1;
            pad_d.oe[pmx_pkg::PAD_RST]  = 1'b1;
            pad_d.pu  = pad_d.pu | pmx_pkg::JTAG_PU_MASK;
            pad_d.oe  = pad_d.oe | pmx_pkg::TRACE_MASK;
            pad_d.out = func_i[0].out & pmx_pkg::TRACE_MASK;
         end
         pmx_pkg::PH_RUN: begin
            pad_d.out = mux_out;
            pad_d.oe  = mux_oe | pmx_pkg::TRACE_MASK;
            pad_d.out[pmx_pkg::PAD_RST] = 1'b0;
            pad_d.oe[pmx_pkg::PAD_RST]  = 1'b0;
            pad_d.pu  = pmx_pkg::JTAG_PU_MASK;
            pad_d.pu[pmx_pkg::PAD_RST]  = 1'b1;
            pad_d.ibe = ibe_vec;
         end
         default: begin
            pad_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pad_q <= '0;
      end else begin
         pad_q <= pad_d;
      end
   end

   // ------------------------------------------------------------
   // input routing
   // ------------------------------------------------------------
   assign live = (phase_q == pmx_pkg::PH_RUN) ? (pad_sync & ibe_vec) : '0;

   for (genvar k = 0; k < pmx_pkg::NUM_SEL; k++) begin : g_sel
      pmx_in_sel u_sel (
         .pads (live),
         .sel  (src_q[k*pmx_pkg::SRC_W +: pmx_pkg::SRC_W]),
         .y    (sel_raw[k])
      );
   end

   always_comb begin
      periph_in_d = live;
      sel_in_d    = sel_raw;
      nmi_d       = nmi_en_q && pad_sync[nmi_idx_q] && (phase_q == pmx_pkg::PH_RUN);
      wakeup_d    = live & pmx_pkg::WAKEUP_MASK;
      ext_irq_d   = live & pmx_pkg::WAKEUP_MASK;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         periph_in_q <= '0;
         sel_in_q    <= '0;
         nmi_q       <= 1'b0;
         wakeup_q    <= '0;
         ext_irq_q   <= '0;
      end else begin
         periph_in_q <= periph_in_d;
         sel_in_q    <= sel_in_d;
         nmi_q       <= nmi_d;
         wakeup_q    <= wakeup_d;
         ext_irq_q   <= ext_irq_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_in_rst;
      phase_q == pmx_pkg::PH_RST;
   endsequence
   sequence s_second_reset_phase_end;
      (phase_q == pmx_pkg::PH_RST && second_reset_phase_done) ##1 phase_q == pmx_pkg::PH_RUN;
   endsequence

   property p_pwr_tristate;
      phase_q == pmx_pkg::PH_PWR |=> (pad_q.oe | pad_q.pu | pad_q.pd) == '0;
   endproperty
   a_pwr_tristate: assert property (p_pwr_tristate)
      else $error("pad active during power-up");

   property p_boot_capture;
      (phase_q == pmx_pkg::PH_RST && second_reset_phase_done)
         |=> boot_from_flash_q == !$past(pad_sync[pmx_pkg::PAD_BOOT]);
   endproperty
   a_boot_capture: assert property (p_boot_capture)
      else $error("boot source not captured");

   property p_rst_pulls;
      s_in_rst |=> pad_q.pd[pmx_pkg::PAD_BOOT] && pad_q.pu[pmx_pkg::PAD_ABS]
         && (pad_q.oe & ~pmx_pkg::TRACE_MASK) == 16'h0004;
   endproperty
   a_rst_pulls: assert property (p_rst_pulls)
      else $error("wrong pulls in reset phase");

   property p_rst_release;
      s_second_reset_phase_end |=> pad_q.pu[pmx_pkg::PAD_RST] && !pad_q.oe[pmx_pkg::PAD_RST];
   endproperty
   a_rst_release: assert property (p_rst_release)
      else $error("reset pad not released to pull-up");

   property p_rst_low;
      s_in_rst |=> pad_q.oe[pmx_pkg::PAD_RST] && !pad_q.out[pmx_pkg::PAD_RST];
   endproperty
   a_rst_low: assert property (p_rst_low)
      else $error("reset pad not driven low");

   property p_jtag;
      s_in_rst |=> (pad_q.pu & pmx_pkg::JTAG_PU_MASK) == pmx_pkg::JTAG_PU_MASK
         && !pad_q.pu[pmx_pkg::PAD_TDO] && !pad_q.oe[pmx_pkg::PAD_TDO];
   endproperty
   a_jtag: assert property (p_jtag)
      else $error("jtag pad state wrong");

   property p_analog_nodrv;
      (pad_q.oe & pmx_pkg::ANALOG_MASK) == '0;
   endproperty
   a_analog_nodrv: assert property (p_analog_nodrv)
      else $error("analog pad driven");

   property p_crystal_out_hiz;
      ((pad_q.oe | pad_q.pu | pad_q.pd) & pmx_pkg::CRYSTAL_OUT_MASK) == '0;
   endproperty
   a_crystal_out_hiz: assert property (p_crystal_out_hiz)
      else $error("crystal pad not high impedance");

   property p_trace_out;
      phase_q != pmx_pkg::PH_PWR |=> (pad_q.oe & pmx_pkg::TRACE_MASK) == pmx_pkg::TRACE_MASK;
   endproperty
   a_trace_out: assert property (p_trace_out)
      else $error("trace pad not output");

   property p_af_two;
      (phase_q == pmx_pkg::PH_RUN && pcr_q[pmx_pkg::PAD_GPIO][1:0] == 2'h2
         && !nmi_hit[pmx_pkg::PAD_GPIO])
         |=> pad_q.out[pmx_pkg::PAD_GPIO] == $past(func_i[2].out[pmx_pkg::PAD_GPIO])
         && pad_q.oe[pmx_pkg::PAD_GPIO] == $past(func_i[2].oe[pmx_pkg::PAD_GPIO]);
   endproperty
   a_af_two: assert property (p_af_two)
      else $error("function two not routed");

   property p_ibe_gate;
      1'b1 |=> periph_in_q == ($past(pad_sync) & pad_q.ibe);
   endproperty
   a_ibe_gate: assert property (p_ibe_gate)
      else $error("input passed without buffer enable");

   property p_src_sel;
      (phase_q == pmx_pkg::PH_RUN && src_q[3:0] == 4'h5)
         |=> sel_in_q[0] == ($past(pad_sync[pmx_pkg::PAD_SRC]) && pad_q.ibe[pmx_pkg::PAD_SRC]);
   endproperty
   a_src_sel: assert property (p_src_sel)
      else $error("source select wrong");

   property p_nmi_prio;
      (nmi_en_q && nmi_idx_q == 4'hD) |=> !pad_q.oe[pmx_pkg::PAD_GPIO];
   endproperty
   a_nmi_prio: assert property (p_nmi_prio)
      else $error("nmi pad still driven");

   property p_wake_irq;
      1'b1 |=> ext_irq_q == ($past(pad_sync) & pad_q.ibe & pmx_pkg::WAKEUP_MASK);
   endproperty
   a_wake_irq: assert property (p_wake_irq)
      else $error("wakeup pad lacks interrupt");

   property p_empty_slot;
      (phase_q == pmx_pkg::PH_RUN && pcr_q[pmx_pkg::PAD_BOOT][1:0] == 2'h3)
         |=> !pad_q.oe[pmx_pkg::PAD_BOOT];
   endproperty
   a_empty_slot: assert property (p_empty_slot)
      else $error("empty slot drives pad");
endmodule // pmx_top

// File: tb/pmx_top_test.sv
// pmx_top_test: self-checking bench for the pad reset-state and function mux
`timescale 1ns/1ps
module pmx_top_test;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                                          clk;
   logic                                          rst_b;
   logic                                          power_up_done;
   logic                                          second_reset_phase_done;
   pmx_pkg::pmx_bus_s                             bus_i;
   logic [31:0]                                   rdata_q;
   pmx_pkg::pmx_vec_t                             pad_in;
   pmx_pkg::pmx_pad_s                             pad_q;
   pmx_pkg::pmx_func_s [pmx_pkg::NUM_SLOTS-1:0]   func_i;
   pmx_pkg::pmx_vec_t                             periph_in_q;
   logic [pmx_pkg::NUM_SEL-1:0]                   sel_in_q;
   logic                                          nmi_q;
   pmx_pkg::pmx_vec_t                             wakeup_q;
   pmx_pkg::pmx_vec_t                             ext_irq_q;
   logic                                          boot_from_flash_q;
   logic                                          alt_boot_select_bit0_q;
   logic [31:0]                                   rd;
   int                                            n_errors;
   int                                            compares;

   pmx_top i_dut (
      .clk                     (clk),
      .rst_b                   (rst_b),
      .power_up_done           (power_up_done),
      .second_reset_phase_done (second_reset_phase_done),
      .bus_i                   (bus_i),
      .rdata_q                 (rdata_q),
      .pad_in                  (pad_in),
      .pad_q                   (pad_q),
      .func_i                  (func_i),
      .periph_in_q             (periph_in_q),
      .sel_in_q                (sel_in_q),
      .nmi_q                   (nmi_q),
      .wakeup_q                (wakeup_q),
      .ext_irq_q               (ext_irq_q),
      .boot_from_flash_q       (boot_from_flash_q),
      .alt_boot_select_bit0_q  (alt_boot_select_bit0_q)
   );

   always #20 clk = ~clk;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      bus_i <= '0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus_i <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge clk);
      bus_i <= '0;
      #1;
      d = rdata_q;
   endtask

   task automatic pcr_wr(input int pad, input logic [1:0] af, input logic ibe);
      bus_wr(8'(4 * pad), {29'h0, ibe, af});
   endtask

   task automatic wrap_up();
      $display("TB: counts n_errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_power_up();
      cycles(3);
      chk("pwr pads", 80'h0, pad_q);
      bus_rd(pmx_pkg::REG_STAT, rd);
      chk("pwr status", 80'h0, rd & 32'h3);
      bus_rd(8'h00, rd);
      chk("pcr0 reset", 80'h0, rd);
      bus_rd(pmx_pkg::REG_NMI, rd);
      chk("nmi reset", 80'h0, rd);
   endtask

   task automatic t_reset_phase();
      @(posedge clk);
      power_up_done <= 1'b1;
      cycles(3);
      chk("rst pd", 80'h0001, pad_q.pd);
      chk("rst pu", 80'h003A, pad_q.pu);
      chk("rst oe", 80'h1E04, pad_q.oe);
      chk("rst out2", 80'h0, pad_q.out[2]);
      bus_rd(pmx_pkg::REG_STAT, rd);
      chk("rst status", 80'h1, rd & 32'h3);
   endtask

   task automatic t_run_phase();
      @(posedge clk);
      second_reset_phase_done <= 1'b1;
      cycles(3);
      bus_rd(pmx_pkg::REG_STAT, rd);
      chk("run status", 80'hE, rd);
      chk("flash boot", 80'h1, boot_from_flash_q);
      chk("abs bit0", 80'h1, alt_boot_select_bit0_q);
      chk("run rst pad", 80'h1, {pad_q.oe[2], pad_q.pu[2]});
      chk("run jtag pu", 80'h7, pad_q.pu[6:3]);
      chk("run trace oe", 80'hF, pad_q.oe[12:9]);
   endtask

   task automatic t_af_codes();
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         for (int s = 0; s < 4; s++) begin
            func_i[s].oe <= 16'hFFFF;
            func_i[s].out <= (s == k) ? 16'hFFFF : 16'h0000;
         end
         pcr_wr(13, 2'(k), 1'b0);
         pcr_wr(6, 2'(k), 1'b0);
         pcr_wr(14, 2'(k), 1'b0);
         pcr_wr(7, 2'(k), 1'b0);
         pcr_wr(0, 2'(k), 1'b0);
         cycles(3);
         chk("af gpio", 80'h3, {pad_q.oe[13], pad_q.out[13]});
         chk("af tdo", 80'((k == 0) || (k == 3)), pad_q.oe[6]);
         chk("af boot", 80'(k < 2), pad_q.oe[0]);
         chk("no drive", 80'h0, pad_q.oe & pmx_pkg::NO_DRV_MASK);
      end
   endtask

   task automatic t_input_buffer();
      @(posedge clk);
      pad_in <= 16'h2002;
      pcr_wr(13, 2'h3, 1'b0);
      cycles(4);
      chk("ibe off", 80'h0, periph_in_q[13]);
      pcr_wr(13, 2'h3, 1'b1);
      pcr_wr(1, 2'h0, 1'b1);
      cycles(4);
      chk("ibe on", 80'h1, {pad_q.ibe[13], periph_in_q[13]} == 2'h3);
      chk("wakeup", 80'h2002, wakeup_q);
      chk("ext irq", 80'h2002, ext_irq_q);
   endtask

   task automatic t_source_select();
      @(posedge clk);
      pad_in <= 16'h2022;
      pcr_wr(5, 2'h3, 1'b1);
      bus_wr(pmx_pkg::REG_SRC, 32'h0000_00D5);
      cycles(4);
      chk("src sel hi", 80'h3, sel_in_q[1:0]);
      @(posedge clk);
      pad_in <= 16'h0002;
      cycles(4);
      chk("src sel lo", 80'h0, sel_in_q[1:0]);
      bus_rd(pmx_pkg::REG_SRC, rd);
      chk("src readback", 80'hD5, rd);
   endtask

   task automatic t_nmi();
      @(posedge clk);
      pad_in <= 16'h2002;
      bus_wr(pmx_pkg::REG_NMI, 32'h0000_00D1);
      cycles(4);
      chk("nmi oe", 80'h0, pad_q.oe[13]);
      chk("nmi level", 80'h1, nmi_q);
      bus_wr(pmx_pkg::REG_NMI, 32'h0);
      cycles(3);
      chk("nmi off oe", 80'h1, pad_q.oe[13]);
      chk("nmi off level", 80'h0, nmi_q);
   endtask

   task automatic t_regs();
      bus_rd(8'h50, rd);
      chk("unmapped", 80'h0, rd);
      cycles(1);
      chk("rdata drop", 80'h0, rdata_q);
      bus_rd(8'h35, rd);
      chk("unaligned", 80'h0, rd);
      bus_wr(pmx_pkg::REG_STAT, 32'h0);
      bus_rd(pmx_pkg::REG_STAT, rd);
      chk("status ro", 80'hE, rd);
      bus_rd(8'h34, rd);
      chk("pcr13 back", 80'h7, rd);
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      power_up_done = 1'b0;
      second_reset_phase_done = 1'b0;
      bus_i = '0;
      func_i = '0;
      pad_in = 16'h0002;
      n_errors = 0;
      compares = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_power_up();
      t_reset_phase();
      t_run_phase();
      t_af_codes();
      t_input_buffer();
      t_source_select();
      t_nmi();
      t_regs();
      wrap_up();
   end

   initial begin
      #(40 * 5000);
      n_errors++;
      wrap_up();
   end
endmodule // pmx_top_test
